// ---- rtct_params.svh ----
// constants for the real-time clock counting core
`ifndef RTCT_PARAMS_SVH
`define RTCT_PARAMS_SVH

`define RTCT_OFF_CONTROL     8'h00
`define RTCT_OFF_SEC_HIGH    8'h04
`define RTCT_OFF_SEC_LOW     8'h08
`define RTCT_OFF_SUBSEC      8'h0c
`define RTCT_OFF_ALARM_HIGH  8'h10
`define RTCT_OFF_ALARM_LOW   8'h14
`define RTCT_OFF_SS_RELOAD   8'h18
`define RTCT_OFF_TRIM        8'h1c

`define RTCT_BIT_RUN         0
`define RTCT_BIT_TOD_EN      1
`define RTCT_BIT_SS_EN       2
`define RTCT_BIT_BUSY        3
`define RTCT_BIT_STABLE      4
`define RTCT_BIT_TOD_FLAG    6
`define RTCT_BIT_SS_FLAG     7
`define RTCT_BIT_ALT_CLK     13
`define RTCT_BIT_UNLOCK      15
`define RTCT_BIT_TRIM_SIGN   5

`define RTCT_PRE_LAST        7'h7f
`define RTCT_PRE_WARN        7'h7e
`define RTCT_ALT_DIV_LAST    7'h7f
`define RTCT_SUB_LAST        8'hff
`define RTCT_TRIM_PERIOD_MSK 4'hf
`define RTCT_ALARM_BITS      20

`endif

// ---- rtct_pkg.sv ----
// types for the real-time clock counting core
`default_nettype none
package rtct_pkg;

    typedef enum logic [1:0] {
        RTCT_PH_IDLE = 2'b01,
        RTCT_PH_ACK  = 2'b10
    } rtct_phase_t;

    typedef struct packed {
        logic [31:0] sec;
        logic [7:0]  sub;
        logic [3:0]  alarm_high;
        logic [15:0] alarm_low;
        logic [15:0] ss_reload;
        logic [15:0] ss_cnt;
        logic        trim_sign;
        logic [4:0]  trim_magnitude;
        logic [4:0]  trim_acc;
        logic        trim_skip;
        logic [6:0]  pre;
        logic [6:0]  alt_div;
        logic        run;
        logic        tod_en;
        logic        ss_en;
        logic        unlock;
        logic        alt_clock_select;
        logic        ss_flag;
        logic        tod_flag;
        logic        stable;
        logic        busy;
        logic        clk32_s1;
        logic        clk32_s2;
        logic        clk32_last;
        rtct_phase_t phase;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } rtct_state_t;

endpackage : rtct_pkg
`default_nettype wire

// ---- rtct_core.sv ----
// real-time clock counting core with alarms, trim and an apb register slave
//
// Summary of operation
// - time is an 8-bit sub-second counter cascaded into 32-bit seconds, two halves
// - sub-second counter steps on each 256Hz tick from 32kHz or alternate source
// - each sub-second rollover advances the seconds counter by one
// - count registers writable only while counter stopped and not busy
// - alarm compares its 20 bits with the low 20 seconds bits
// - alarm-high keeps 4 bits, upper 28 bits read as zero
// - alarm registers writable only while alarm disabled and not busy
// - sub-second alarm timer reloads from its register, each reload sets flag
// - sub-second reload register is 16 bits wide
// - reload register writable only while sub-second alarm disabled and not busy
// - trim sign zero adds time, one removes time
// - trim fields always readable, writable only while unlock is set
// - trim magnitude accumulates every 16 seconds
// - accumulator carry adds or removes 128 cycles of the selected source (32kHz or alternate) from the chain
// - power-on reset clears all but busy, which it sets, and phase, which it loads idle; system reset keeps count and trim
// - alarm flag sets when low 20 seconds bits equal the alarm value
// - busy rises on count write or enable change, clears on the next tick of the selected source (32kHz or alternate)
// - stable flag clears just before a chain update and sets after it
// - chain ticks only while run enable is set, holds otherwise
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "rtct_params.svh"

module rtct_core (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        sys_reset,
    input  wire logic        clk32_in,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output logic             tod_alarm_flag,
    output logic             subsecond_alarm_flag
);
    import rtct_pkg::*;

    rtct_state_t st_reg;
    rtct_state_t st_next;

    // true when the address is one of the mapped words
    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a == `RTCT_OFF_CONTROL) || (a == `RTCT_OFF_SEC_HIGH) ||
                      (a == `RTCT_OFF_SEC_LOW) || (a == `RTCT_OFF_SUBSEC) ||
                      (a == `RTCT_OFF_ALARM_HIGH) || (a == `RTCT_OFF_ALARM_LOW) ||
                      (a == `RTCT_OFF_SS_RELOAD) || (a == `RTCT_OFF_TRIM);
    endfunction : addr_mapped

    function automatic logic [31:0] read_word(input rtct_state_t s, input logic [7:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            `RTCT_OFF_CONTROL: begin
                w[`RTCT_BIT_RUN]      = s.run;
                w[`RTCT_BIT_TOD_EN]   = s.tod_en;
                w[`RTCT_BIT_SS_EN]    = s.ss_en;
                w[`RTCT_BIT_BUSY]     = s.busy;
                w[`RTCT_BIT_STABLE]   = s.stable;
                w[`RTCT_BIT_TOD_FLAG] = s.tod_flag;
                w[`RTCT_BIT_SS_FLAG]  = s.ss_flag;
                w[`RTCT_BIT_ALT_CLK]  = s.alt_clock_select;
                w[`RTCT_BIT_UNLOCK]   = s.unlock;
            end
            `RTCT_OFF_SEC_HIGH:   w[15:0] = s.sec[31:16];
            `RTCT_OFF_SEC_LOW:    w[15:0] = s.sec[15:0];
            `RTCT_OFF_SUBSEC:     w[7:0]  = s.sub;
            `RTCT_OFF_ALARM_HIGH: w[3:0]  = s.alarm_high;
            `RTCT_OFF_ALARM_LOW:  w[15:0] = s.alarm_low;
            `RTCT_OFF_SS_RELOAD:  w[15:0] = s.ss_reload;
            `RTCT_OFF_TRIM: begin
                w[`RTCT_BIT_TRIM_SIGN] = s.trim_sign;
                w[4:0]                 = s.trim_magnitude;
            end
            default:              w = 32'h0000_0000;
        endcase
        read_word = w;
    endfunction : read_word

    logic        setup;
    logic        wr;
    logic        tick32;
    logic        tick256;
    logic        sec_step;
    logic [31:0] sec_inc;
    logic [5:0]  trim_sum;
    logic        trim_carry;
    logic        ss_reload_ev;
    logic        tod_match_ev;
    logic        cnt_wr_ok;
    logic        new_run;
    logic        new_tod_en;
    logic        new_ss_en;

    always_comb begin
        st_next = st_reg;
        setup   = psel && !penable;
        wr      = psel && penable && pwrite && st_reg.pready;

        // pin is foreign to pclk: two flops before any logic looks at it
        st_next.clk32_s1   = clk32_in;
        st_next.clk32_s2   = st_reg.clk32_s1;
        st_next.clk32_last = st_reg.clk32_s2;

        // alternate source is pclk divided by 128, kept as a one-cycle enable
        st_next.alt_div = st_reg.alt_div + 7'h01;
        tick32 = st_reg.alt_clock_select ? (st_reg.alt_div == `RTCT_ALT_DIV_LAST)
                                         : (st_reg.clk32_s2 && !st_reg.clk32_last);

        // 256Hz tick: every 128th source cycle, only while running
        tick256 = 1'b0;
        if (st_reg.run && tick32) begin
            st_next.pre = st_reg.pre + 7'h01;
            tick256     = (st_reg.pre == `RTCT_PRE_LAST);
        end

        // negative trim swallows one tick (128 source cycles)
        if (tick256 && st_reg.trim_skip) begin
            tick256           = 1'b0;
            st_next.trim_skip = 1'b0;
            st_next.stable    = 1'b1;   // swallowed tick still ends the window
        end

        // stable flag drops one source cycle ahead of the update
        if (st_reg.run && tick32 && st_reg.pre == `RTCT_PRE_WARN) begin
            st_next.stable = 1'b0;
        end

        // synchronous chain, every bit moves on the same edge
        sec_step = 1'b0;
        sec_inc  = st_reg.sec + 32'h0000_0001;
        if (tick256) begin
            st_next.sub    = st_reg.sub + 8'h01;
            st_next.stable = 1'b1;
            if (st_reg.sub == `RTCT_SUB_LAST) begin
                sec_step    = 1'b1;
                st_next.sec = sec_inc;
            end
        end

        // trim accumulates each time the seconds pass a multiple of 16
        trim_sum   = {1'b0, st_reg.trim_acc} + {1'b0, st_reg.trim_magnitude};
        trim_carry = 1'b0;
        if (sec_step && (sec_inc[3:0] & `RTCT_TRIM_PERIOD_MSK) == 4'h0) begin
            st_next.trim_acc = trim_sum[4:0];
            trim_carry       = trim_sum[5];
        end
        if (trim_carry) begin
            if (st_reg.trim_sign) begin
                st_next.trim_skip = 1'b1;
            end else begin
                // positive trim: step the sub-second counter one extra 256Hz period
                st_next.sub = st_next.sub + 8'h01;
            end
        end

        // sub-second alarm timer: counts 256Hz ticks, reloads at zero
        ss_reload_ev = 1'b0;
        if (st_reg.ss_en && tick256) begin
            if (st_reg.ss_cnt == 16'h0000) begin
                st_next.ss_cnt = st_reg.ss_reload;
                ss_reload_ev   = 1'b1;
            end else begin
                st_next.ss_cnt = st_reg.ss_cnt - 16'h0001;
            end
        end

        // time-of-day alarm on the new seconds value
        tod_match_ev = st_reg.tod_en && sec_step &&
                       (sec_inc[`RTCT_ALARM_BITS-1:0] ==
                        {st_reg.alarm_high, st_reg.alarm_low});

        // busy is released by the first source edge after it was raised
        if (tick32) begin
            st_next.busy = 1'b0;
        end

        // apb slave: zero wait states, answer registered in the setup cycle
        st_next.pready  = 1'b0;
        st_next.phase   = RTCT_PH_IDLE;
        if (setup) begin
            st_next.pready  = 1'b1;
            st_next.phase   = RTCT_PH_ACK;
            st_next.pslverr = !addr_mapped(paddr);
            st_next.prdata  = pwrite ? 32'h0000_0000 : read_word(st_reg, paddr);
        end else begin
            st_next.pslverr = 1'b0;
        end

        cnt_wr_ok  = !st_reg.run && !st_reg.busy;
        new_run    = st_reg.run;
        new_tod_en = st_reg.tod_en;
        new_ss_en  = st_reg.ss_en;
        if (wr) begin
            case (paddr)
                `RTCT_OFF_CONTROL: begin
                    // run only moves while unlocked; the source only while stopped
                    if (st_reg.unlock) begin
                        new_run = pwdata[`RTCT_BIT_RUN];
                    end
                    if (!st_reg.run) begin
                        st_next.alt_clock_select = pwdata[`RTCT_BIT_ALT_CLK];
                    end
                    new_tod_en     = pwdata[`RTCT_BIT_TOD_EN];
                    new_ss_en      = pwdata[`RTCT_BIT_SS_EN];
                    st_next.unlock = pwdata[`RTCT_BIT_UNLOCK];
                    if (!pwdata[`RTCT_BIT_TOD_FLAG]) begin
                        st_next.tod_flag = 1'b0;
                    end
                    if (!pwdata[`RTCT_BIT_SS_FLAG]) begin
                        st_next.ss_flag = 1'b0;
                    end
                    if (!pwdata[`RTCT_BIT_STABLE] && !tick256) begin
                        st_next.stable = 1'b0;
                    end
                end
                `RTCT_OFF_SEC_HIGH: if (cnt_wr_ok) begin
                    st_next.sec[31:16] = pwdata[15:0];
                    st_next.busy       = 1'b1;
                end
                `RTCT_OFF_SEC_LOW: if (cnt_wr_ok) begin
                    st_next.sec[15:0] = pwdata[15:0];
                    st_next.busy      = 1'b1;
                end
                `RTCT_OFF_SUBSEC: if (cnt_wr_ok) begin
                    st_next.sub  = pwdata[7:0];
                    st_next.busy = 1'b1;
                end
                `RTCT_OFF_ALARM_HIGH: if (!st_reg.tod_en && !st_reg.busy) begin
                    st_next.alarm_high = pwdata[3:0];
                end
                `RTCT_OFF_ALARM_LOW: if (!st_reg.tod_en && !st_reg.busy) begin
                    st_next.alarm_low = pwdata[15:0];
                end
                `RTCT_OFF_SS_RELOAD: if (!st_reg.ss_en && !st_reg.busy) begin
                    st_next.ss_reload = pwdata[15:0];
                end
                `RTCT_OFF_TRIM: if (st_reg.unlock) begin
                    st_next.trim_sign      = pwdata[`RTCT_BIT_TRIM_SIGN];
                    st_next.trim_magnitude = pwdata[4:0];
                end
                default: begin
                end
            endcase
        end
        if (new_run != st_reg.run || new_tod_en != st_reg.tod_en ||
            new_ss_en != st_reg.ss_en) begin
            st_next.busy = 1'b1;
        end
        st_next.run    = new_run;
        st_next.tod_en = new_tod_en;
        st_next.ss_en  = new_ss_en;
        // re-arming the sub-second timer starts it from the reload value
        if (new_ss_en && !st_reg.ss_en) begin
            st_next.ss_cnt = st_reg.ss_reload;
        end

        // hardware set wins over a software clear in the same cycle
        if (ss_reload_ev) begin
            st_next.ss_flag = 1'b1;
        end
        if (tod_match_ev) begin
            st_next.tod_flag = 1'b1;
        end

        // system reset: count and trim survive, handshake state restarts
        if (sys_reset) begin
            st_next.busy    = 1'b1;
            st_next.stable  = 1'b0;
            st_next.unlock  = 1'b0;
            st_next.pready  = 1'b0;
            st_next.pslverr = 1'b0;
            st_next.phase   = RTCT_PH_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg       <= '0;
            st_reg.busy  <= 1'b1;
            st_reg.phase <= RTCT_PH_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pready               = st_reg.pready;
    assign prdata               = st_reg.prdata;
    assign pslverr              = st_reg.pslverr;
    assign tod_alarm_flag       = st_reg.tod_flag;
    assign subsecond_alarm_flag = st_reg.ss_flag;

    a_count_write_lock: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == `RTCT_OFF_SUBSEC && (st_reg.run || st_reg.busy) && !tick256
         && !trim_carry && !sys_reset) |=> st_reg.sub == $past(st_reg.sub))
        else $error("sub-second count changed by a locked write");

    a_run_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (!st_reg.run && !(wr && paddr == `RTCT_OFF_SUBSEC) && !sys_reset)
        |=> st_reg.sub == $past(st_reg.sub))
        else $error("sub-second count moved while stopped");

    a_sec_carry: assert property (@(posedge pclk) disable iff (!presetn)
        (tick256 && st_reg.sub == `RTCT_SUB_LAST && !wr)
        |=> st_reg.sec == $past(st_reg.sec) + 32'h0000_0001)
        else $error("seconds did not advance on sub-second rollover");

    a_alarm_high_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == `RTCT_OFF_ALARM_HIGH) |=> prdata[31:4] == 28'h0)
        else $error("alarm-high reserved bits not zero");

    a_tod_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        tod_match_ev && !sys_reset |=> st_reg.tod_flag)
        else $error("time-of-day flag missed a match");

    a_ss_reload_flag: assert property (@(posedge pclk) disable iff (!presetn)
        ss_reload_ev |=> st_reg.ss_flag && st_reg.ss_cnt == $past(st_reg.ss_reload))
        else $error("sub-second reload did not set the flag");

    a_trim_lock: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == `RTCT_OFF_TRIM && !st_reg.unlock)
        |=> st_reg.trim_magnitude == $past(st_reg.trim_magnitude))
        else $error("trim written while locked");

    a_busy_on_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == `RTCT_OFF_SEC_LOW && cnt_wr_ok) |=> st_reg.busy)
        else $error("busy not raised by a count write");

    a_stable_drop: assert property (@(posedge pclk) disable iff (!presetn)
        (st_reg.run && tick32 && st_reg.pre == `RTCT_PRE_WARN && !sys_reset)
        |=> !st_reg.stable)
        else $error("stable flag not cleared before update");

    a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !sys_reset) |=> st_reg.pready ##1 !st_reg.pready)
        else $error("apb answer not one cycle after setup");

    a_alarm_lock: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == `RTCT_OFF_ALARM_HIGH && (st_reg.tod_en || st_reg.busy))
        |=> st_reg.alarm_high == $past(st_reg.alarm_high))
        else $error("alarm written while locked");

    a_reload_lock: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == `RTCT_OFF_SS_RELOAD && (st_reg.ss_en || st_reg.busy))
        |=> st_reg.ss_reload == $past(st_reg.ss_reload))
        else $error("sub-second reload written while locked");

    a_trim_period: assert property (@(posedge pclk) disable iff (!presetn)
        (!sec_step || (sec_inc[3:0] & `RTCT_TRIM_PERIOD_MSK) != 4'h0)
        |=> st_reg.trim_acc == $past(st_reg.trim_acc))
        else $error("trim accumulated off the 16 second boundary");

    a_trim_add: assert property (@(posedge pclk) disable iff (!presetn)
        (trim_carry && !st_reg.trim_sign) |=> st_reg.sub == 8'h01)
        else $error("positive trim did not add a sub-second step");

    a_trim_skip: assert property (@(posedge pclk) disable iff (!presetn)
        (trim_carry && st_reg.trim_sign) |=> st_reg.trim_skip)
        else $error("negative trim did not arm a skipped tick");

    a_sys_keep: assert property (@(posedge pclk) disable iff (!presetn)
        (sys_reset && !sec_step && !wr)
        |=> st_reg.sec == $past(st_reg.sec)
            && st_reg.trim_magnitude == $past(st_reg.trim_magnitude))
        else $error("system reset disturbed count or trim");

    a_busy_release: assert property (@(posedge pclk) disable iff (!presetn)
        (st_reg.busy && tick32 && !wr && !sys_reset) |=> !st_reg.busy)
        else $error("busy not released by a source tick");

endmodule : rtct_core
`default_nettype wire

// ---- rtc_counter_alarm_trim_bench.sv ----
// self-checking bench for the real-time clock counting core
`timescale 1ns/1ps
`default_nettype none
`include "rtct_params.svh"

module rtc_counter_alarm_trim_bench;
    import rtct_pkg::*;

    localparam logic [7:0] AD_CT = `RTCT_OFF_CONTROL;
    localparam logic [7:0] AD_SH = `RTCT_OFF_SEC_HIGH;
    localparam logic [7:0] AD_SL = `RTCT_OFF_SEC_LOW;
    localparam logic [7:0] AD_SS = `RTCT_OFF_SUBSEC;
    localparam logic [7:0] AD_AH = `RTCT_OFF_ALARM_HIGH;
    localparam logic [7:0] AD_AL = `RTCT_OFF_ALARM_LOW;
    localparam logic [7:0] AD_RL = `RTCT_OFF_SS_RELOAD;
    localparam logic [7:0] AD_TR = `RTCT_OFF_TRIM;

    logic        pclk;
    logic        presetn;
    logic        sys_reset;
    logic        clk32_in = 1'b0;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        tod_alarm_flag;
    logic        subsecond_alarm_flag;
    logic        run32;
    logic        last_err;
    logic [2:0]  div32 = 3'h0;
    logic [31:0] rdv;
    logic [31:0] s0;
    int          err_total;
    int          checked;

    rtct_core rtct_core_i (
        .pclk                 (pclk),
        .presetn              (presetn),
        .sys_reset            (sys_reset),
        .clk32_in             (clk32_in),
        .psel                 (psel),
        .penable              (penable),
        .pwrite               (pwrite),
        .paddr                (paddr),
        .pwdata               (pwdata),
        .pready               (pready),
        .prdata               (prdata),
        .pslverr              (pslverr),
        .tod_alarm_flag       (tod_alarm_flag),
        .subsecond_alarm_flag (subsecond_alarm_flag)
    );

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // 32k source sped up to pclk/8 so a whole run stays short; it can be held still
    always @(posedge pclk) begin
        div32 <= div32 + 3'h1;
        if (run32) begin
            clk32_in <= div32[2];
        end
    end

    task automatic stop_test();
        $display("counts: checked %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask : chk

    // request held until the edge where pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            chk("pready", 32'h1, 32'h0);
            stop_test();
        end
        rdv      = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rdv);
    endtask : rdc

    task automatic wait_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                            input int lim);
        int n;
        n = 0;
        do begin
            apb(1'b0, a, 32'h0);
            n++;
        end while ((rdv & m) !== e && n < lim);
        chk("polled field", e, rdv & m);
        if ((rdv & m) !== e) begin
            stop_test();
        end
    endtask : wait_reg

    initial begin
        presetn   = 1'b0;
        sys_reset = 1'b0;
        run32     = 1'b1;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 8'h00;
        pwdata    = 32'h0;
        err_total = 0;
        checked   = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 1; i < 8; i++) begin
            rdc(8'(4 * i), 32'h0, "power-on value");
        end
        wait_reg(AD_CT, 32'h8, 32'h0, 200);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped read", 32'h0, rdv);
        chk("unmapped error", 32'h1, {31'h0, last_err});
        $display("test reset and map done");
        apb(1'b1, AD_TR, 32'hff);
        rdc(AD_TR, 32'h0, "trim locked");
        apb(1'b1, AD_CT, 32'h8000);
        apb(1'b1, AD_TR, 32'hff);
        rdc(AD_TR, 32'h3f, "trim open");
        apb(1'b1, AD_TR, 32'h25);
        rdc(AD_TR, 32'h25, "trim sign");
        apb(1'b1, AD_AH, 32'hff);
        rdc(AD_AH, 32'h0f, "alarm high");
        apb(1'b1, AD_AH, 32'h02);
        apb(1'b1, AD_AL, 32'h0);
        apb(1'b1, AD_RL, 32'hffffffff);
        rdc(AD_RL, 32'hffff, "reload width");
        apb(1'b1, AD_RL, 32'h3);
        $display("test register fields done");
        // source held still so busy cannot clear before it is read
        run32 <= 1'b0;
        apb(1'b1, AD_SH, 32'h1231);
        rdc(AD_CT, 32'h8008, "busy after count write");
        run32 <= 1'b1;
        wait_reg(AD_CT, 32'h8, 32'h0, 100);
        apb(1'b1, AD_SL, 32'hffff);
        wait_reg(AD_CT, 32'h8, 32'h0, 100);
        apb(1'b1, AD_SS, 32'hfe);
        wait_reg(AD_CT, 32'h8, 32'h0, 100);
        rdc(AD_SH, 32'h1231, "seconds high");
        rdc(AD_SL, 32'hffff, "seconds low");
        rdc(AD_SS, 32'hfe, "sub-seconds");
        apb(1'b1, AD_CT, 32'h80d7);
        wait_reg(AD_CT, 32'h8, 32'h0, 100);
        apb(1'b1, AD_SL, 32'h1234);
        apb(1'b1, AD_SS, 32'h55);
        apb(1'b1, AD_AH, 32'h05);
        apb(1'b1, AD_RL, 32'h9);
        rdc(AD_AH, 32'h02, "alarm locked");
        rdc(AD_RL, 32'h3, "reload locked");
        chk("tod flag early", 32'h0, {31'h0, tod_alarm_flag});
        wait_reg(AD_SL, 32'hffff, 32'h0, 3000);
        wait_reg(AD_CT, 32'h10, 32'h10, 1000);
        rdc(AD_SH, 32'h1232, "seconds carry");
        rdc(AD_SS, 32'h0, "sub-second wrap");
        chk("tod flag", 32'h1, {31'h0, tod_alarm_flag});
        wait_reg(AD_CT, 32'h10, 32'h10, 3000);
        wait_reg(AD_CT, 32'h80, 32'h80, 4000);
        chk("sub-second flag", 32'h1, {31'h0, subsecond_alarm_flag});
        $display("test running chain done");
        sys_reset <= 1'b1;
        @(posedge pclk);
        sys_reset <= 1'b0;
        wait_reg(AD_CT, 32'h10, 32'h10, 1000);
        rdc(AD_SH, 32'h1232, "seconds kept");
        rdc(AD_TR, 32'h25, "trim kept");
        apb(1'b1, AD_CT, 32'h8000);
        apb(1'b1, AD_CT, 32'h8000);
        wait_reg(AD_CT, 32'h9, 32'h0, 100);
        apb(1'b0, AD_SS, 32'h0);
        s0 = rdv;
        repeat (2500) @(posedge pclk);
        rdc(AD_SS, s0, "chain held");
        $display("test system reset and stop done");
        // carry at the next 16 second boundary: sign 0 adds a step, sign 1 swallows one
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, AD_TR, k ? 32'h3f : 32'h1f);
            apb(1'b1, AD_SL, 32'hffff);
            wait_reg(AD_CT, 32'h8, 32'h0, 100);
            apb(1'b1, AD_SS, 32'hff);
            wait_reg(AD_CT, 32'h8, 32'h0, 100);
            apb(1'b1, AD_CT, 32'h8001);
            wait_reg(AD_SL, 32'hffff, 32'h0, 1000);
            repeat (1500) @(posedge pclk);
            rdc(AD_SS, k ? 32'h0 : 32'h2, "trim step");
            apb(1'b1, AD_CT, 32'h8000);
            wait_reg(AD_CT, 32'h9, 32'h0, 100);
        end
        $display("test trim done");
        // alternate source alone may move the chain now
        run32 <= 1'b0;
        apb(1'b1, AD_CT, 32'ha000);
        apb(1'b1, AD_CT, 32'ha001);
        wait_reg(AD_CT, 32'h8, 32'h0, 200);
        apb(1'b0, AD_SS, 32'h0);
        wait_reg(AD_SS, 32'hff, (rdv + 32'h1) & 32'hff, 8000);
        $display("test alternate source done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 1; i < 8; i++) begin
            rdc(8'(4 * i), 32'h0, "cleared by power-on");
        end
        $display("test second power-on done");
        stop_test();
    end

endmodule : rtc_counter_alarm_trim_bench

`default_nettype wire
